/* hdl/remote_status_io_consts.vh */
// Purpose: Shared constants of the remote status I/O block
// Assumes: 250 MHz system clock, APB register access
// Notes:   Included by bare name; definitions only
`ifndef REMOTE_STATUS_IO_CONSTS_VH
`define REMOTE_STATUS_IO_CONSTS_VH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RSIO_CLK_NS          4
`define RSIO_TICK_NS         1000000
`define RSIO_TICK_CYCLES     (`RSIO_TICK_NS / `RSIO_CLK_NS)
`define RSIO_PULSE_MIN_MS    10
`define RSIO_TICK_CNT_W      18
`define RSIO_PULSE_CNT_W     8

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define RSIO_ADDR_W          12
`define RSIO_OFS_CTRL_STAT   12'h000
`define RSIO_OFS_GROUP       12'h004
`define RSIO_OFS_EVENTS      12'h008
`define RSIO_OFS_REMOTE      12'h00C
`define RSIO_OFS_OUTPUTS     12'h010
`define RSIO_OFS_MNP_BASE    6'h01

// ----------------------------------------------------------------------
// Controller status bits, written by software
// ----------------------------------------------------------------------
`define RSIO_CS_RUN          0
`define RSIO_CS_PAUSE        1
`define RSIO_CS_RESET        2
`define RSIO_CS_DOOR         3
`define RSIO_CS_ENABLE       4
`define RSIO_CS_ESTOP        5
`define RSIO_CS_ERROR        6
`define RSIO_CS_AUTO         7
`define RSIO_CS_SUPERVISED   8
`define RSIO_CS_READY        9
`define RSIO_CS_W            10
`define RSIO_CS_RESET_VAL    10'h000

// ----------------------------------------------------------------------
// Per-manipulator status bits
// ----------------------------------------------------------------------
`define RSIO_MS_MOTOR_MODE   0
`define RSIO_MS_MOTOR_STAT   1
`define RSIO_MS_POWER_MODE   2
`define RSIO_MS_POWER_STAT   3
`define RSIO_MS_CALIBRATED   4
`define RSIO_MS_HOME         5
`define RSIO_MS_W            6
`define RSIO_MS_RESET_VAL    6'h00

// ----------------------------------------------------------------------
// Remote command inputs and event bits
// ----------------------------------------------------------------------
`define RSIO_CMD_MOTOR_ON    0
`define RSIO_CMD_MOTOR_OFF   1
`define RSIO_CMD_CALIBRATE   2
`define RSIO_CMD_HOME        3
`define RSIO_CMD_SEL_MNP     4
`define RSIO_CMD_START       5
`define RSIO_CMD_PAUSE       6
`define RSIO_CMD_RESET       7
`define RSIO_CMD_RECOVER     8
`define RSIO_CMD_RESTART     9
`define RSIO_CMD_ABORT_ALL   10
`define RSIO_CMD_READY       11
`define RSIO_CMD_W           12
`define RSIO_EV_COLLISION    12
`define RSIO_EV_W            13
`define RSIO_NUM_W           4

`endif

/* hdl/remote_input_filter.v */
// Purpose: Synchronise and qualify pulse-type remote input pins
// Assumes: tick is a one-cycle pulse once per millisecond
// Notes:   Level counts after held high for PULSE_TICKS ticks
`timescale 1ns/1ps
`include "remote_status_io_consts.vh"

module remote_input_filter
#(
  parameter WIDTH       = 20,
  parameter PULSE_TICKS = `RSIO_PULSE_MIN_MS
)
(
  input  wire             clk_sys,
  input  wire             rst,
  input  wire             tick,
  input  wire [WIDTH-1:0] pinIn,
  output wire [WIDTH-1:0] level,
  output wire [WIDTH-1:0] pulse
);

  localparam [`RSIO_PULSE_CNT_W-1:0] TICKS_NEED =
    PULSE_TICKS[`RSIO_PULSE_CNT_W-1:0];

  genvar i;

  // ----------------------------------------------------------------------
  // One qualifier per input bit
  // ----------------------------------------------------------------------
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : gBit
      reg                         sync1_reg;
      reg                         sync2_reg;
      reg                         sync3_reg;
      reg [`RSIO_PULSE_CNT_W-1:0] held_reg;
      reg                         level_reg;
      reg                         pulse_reg;

      // Three-stage synchroniser; first stage feeds only the second
      always @(posedge clk_sys)
      begin
        if (rst)
        begin
          sync1_reg <= 1'b0;
          sync2_reg <= 1'b0;
          sync3_reg <= 1'b0;
        end
        else
        begin
          sync1_reg <= pinIn[i];
          sync2_reg <= sync1_reg;
          sync3_reg <= sync2_reg;
        end
      end

      // Width qualifier: agreed high level counted in millisecond ticks
      always @(posedge clk_sys)
      begin
        if (rst)
        begin
          held_reg  <= {`RSIO_PULSE_CNT_W{1'b0}};
          level_reg <= 1'b0;
          pulse_reg <= 1'b0;
        end
        else
        begin
          pulse_reg <= 1'b0;
          if (sync2_reg == sync3_reg)
          begin
            if (!sync3_reg)
            begin
              held_reg  <= {`RSIO_PULSE_CNT_W{1'b0}};
              level_reg <= 1'b0;
            end
            else if (!level_reg && tick)
            begin
              if (held_reg + 1'b1 >= TICKS_NEED)
              begin
                level_reg <= 1'b1;
                pulse_reg <= 1'b1;
              end
              else
                held_reg <= held_reg + 1'b1;
            end
          end
        end
      end

      assign level[i] = level_reg;
      assign pulse[i] = pulse_reg;
    end
  endgenerate

endmodule

/* hdl/remote_status_io.v */
// Purpose: Remote discrete status outputs and pulse command inputs
// Assumes: Software mirrors controller and manipulator state over APB
// Notes:   All outputs registered; APB answers with one wait state
//
// How it works
// - Motor-mode output follows selected manipulator motor-on mode.
// - Motor-status output follows selected manipulator motor status.
// - Power-mode output high for high power mode, low otherwise.
// - Power-status output high while really running in high power.
// - Calibrated output high once origin calibration has been done.
// - Home output shows whether selected manipulator is at home.
// - Per-manipulator outputs come from the latest selected one.
// - Selected manipulator number shown on four output bits.
// - Separate running, paused and reset outputs, high while true.
// - Safety-door output high while the door is open.
// - Enable-switch state of the pendant mirrored onto an output.
// - Separate emergency-stop and error outputs.
// - Selected project group number shown on four output bits.
// - Working-mode output high in automatic, low in programming.
// - Operation-mode output high in supervised mode, else low.
// - Ready output high in ready or reset state.
// - Remote inputs act on a qualified pulse, not a held level.
// - Manipulator N encoded as binary N minus one, bit 0 LSB.
// - Group 0 to 15 encoded as plain binary, bit 0 LSB.
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "remote_status_io_consts.vh"

module remote_status_io
#(
  parameter TICK_CYCLES = `RSIO_TICK_CYCLES,
  parameter PULSE_TICKS = `RSIO_PULSE_MIN_MS,
  parameter NUM_MNP     = 16
)
(
  input  wire                    clk_sys,
  input  wire                    rst,
  // APB slave
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [`RSIO_ADDR_W-1:0] paddr,
  input  wire [31:0]             pwdata,
  output wire [31:0]             prdata,
  output wire                    pready,
  output wire                    pslverr,
  // Remote input pins
  input  wire [`RSIO_CMD_W-1:0]  remoteCmd,
  input  wire [`RSIO_NUM_W-1:0]  remoteMnpNum,
  input  wire [`RSIO_NUM_W-1:0]  remoteGrpNum,
  // Remote status outputs
  output wire                    motorModeOut,
  output wire                    motorStatusOut,
  output wire                    powerModeOut,
  output wire                    powerStatusOut,
  output wire                    originCalibratedOut,
  output wire                    homeOut,
  output wire [`RSIO_NUM_W-1:0]  mnpNumOut,
  output wire                    runningOut,
  output wire                    pausedOut,
  output wire                    resetOut,
  output wire                    safetyDoorOut,
  output wire                    enableSwitchOut,
  output wire                    estopOut,
  output wire                    errorOut,
  output wire [`RSIO_NUM_W-1:0]  grpNumOut,
  output wire                    autoModeOut,
  output wire                    supervisedModeOut,
  output wire                    readyOut
);

  localparam IN_W = `RSIO_CMD_W + 2 * `RSIO_NUM_W;
  localparam [`RSIO_TICK_CNT_W-1:0] TICK_LAST =
    TICK_CYCLES[`RSIO_TICK_CNT_W-1:0] - 1'b1;
  localparam [`RSIO_NUM_W-1:0] LAST_MNP = NUM_MNP[`RSIO_NUM_W-1:0] - 1'b1;

  // APB phases, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // More than one bit set in a command vector
  function multiHot;
    input [`RSIO_CMD_W-1:0] v;
    begin
      multiHot = |(v & (v - 1'b1));
    end
  endfunction

  // Address hits the manipulator status window
  function isMnpAddr;
    input [`RSIO_ADDR_W-1:0] a;
    begin
      isMnpAddr = (a[`RSIO_ADDR_W-1:6] == `RSIO_OFS_MNP_BASE)
                  && (a[5:2] <= LAST_MNP);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  reg [`RSIO_TICK_CNT_W-1:0] divCnt_reg;
  reg                        tick_reg;
  reg [2:0]                  apbState_reg;
  reg [2:0]                  apbState_next;
  reg [31:0]                 prdata_reg;
  reg [31:0]                 prdata_next;
  reg                        pready_reg;
  reg                        pslverr_reg;
  reg                        addrOk;
  reg [`RSIO_CS_W-1:0]       ctrlStat_reg;
  reg [`RSIO_NUM_W-1:0]      group_reg;
  reg [`RSIO_EV_W-1:0]       events_reg;
  reg [`RSIO_EV_W-1:0]       events_next;
  reg [`RSIO_NUM_W-1:0]      sel_reg;
  reg [`RSIO_MS_W-1:0]       mnpStat [0:NUM_MNP-1];
  reg [`RSIO_MS_W-1:0]       selStat;
  reg                        motorMode_reg;
  reg                        motorStatus_reg;
  reg                        powerMode_reg;
  reg                        powerStatus_reg;
  reg                        calibrated_reg;
  reg                        home_reg;
  reg [`RSIO_NUM_W-1:0]      mnpNum_reg;
  reg                        running_reg;
  reg                        paused_reg;
  reg                        resetSt_reg;
  reg                        door_reg;
  reg                        enable_reg;
  reg                        estop_reg;
  reg                        error_reg;
  reg [`RSIO_NUM_W-1:0]      grpNum_reg;
  reg                        auto_reg;
  reg                        supervised_reg;
  reg                        ready_reg;
  wire [IN_W-1:0]            inLevel;
  wire [IN_W-1:0]            inPulse;
  wire [`RSIO_CMD_W-1:0]     cmdLevel;
  wire [`RSIO_CMD_W-1:0]     cmdPulse;
  wire [`RSIO_NUM_W-1:0]     mnpLevel;
  wire [`RSIO_NUM_W-1:0]     grpLevel;
  wire                       wrStrobe;
  wire [31:0]                outVector;
  integer                    k;

  // ----------------------------------------------------------------------
  // Millisecond tick divider
  // ----------------------------------------------------------------------
  // One-cycle enable every TICK_CYCLES clocks
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      divCnt_reg <= {`RSIO_TICK_CNT_W{1'b0}};
      tick_reg   <= 1'b0;
    end
    else if (divCnt_reg >= TICK_LAST)
    begin
      divCnt_reg <= {`RSIO_TICK_CNT_W{1'b0}};
      tick_reg   <= 1'b1;
    end
    else
    begin
      divCnt_reg <= divCnt_reg + 1'b1;
      tick_reg   <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Remote input qualification
  // ----------------------------------------------------------------------
  remote_input_filter
  #(
    .WIDTH       (IN_W),
    .PULSE_TICKS (PULSE_TICKS)
  )
  uInputs
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick    (tick_reg),
    .pinIn   ({remoteGrpNum, remoteMnpNum, remoteCmd}),
    .level   (inLevel),
    .pulse   (inPulse)
  );

  // Split qualified vectors back into their groups
  assign cmdLevel = inLevel[`RSIO_CMD_W-1:0];
  assign cmdPulse = inPulse[`RSIO_CMD_W-1:0];
  assign mnpLevel = inLevel[`RSIO_CMD_W+`RSIO_NUM_W-1:`RSIO_CMD_W];
  assign grpLevel = inLevel[IN_W-1:`RSIO_CMD_W+`RSIO_NUM_W];

  // ----------------------------------------------------------------------
  // Manipulator selection
  // ----------------------------------------------------------------------
  // Select pulse latches the number bits; out of range keeps old choice
  always @(posedge clk_sys)
  begin
    if (rst)
      sel_reg <= {`RSIO_NUM_W{1'b0}};
    else if (cmdPulse[`RSIO_CMD_SEL_MNP] && mnpLevel <= LAST_MNP)
      sel_reg <= mnpLevel;
  end

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  // Write takes effect on the edge where pready is seen high
  assign wrStrobe = psel && penable && pwrite && pready_reg;

  // Address decode for the access in flight
  always @*
  begin
    addrOk = isMnpAddr(paddr);
    case (paddr)
      `RSIO_OFS_CTRL_STAT: addrOk = 1'b1;
      `RSIO_OFS_GROUP:     addrOk = 1'b1;
      `RSIO_OFS_EVENTS:    addrOk = 1'b1;
      `RSIO_OFS_REMOTE:    addrOk = 1'b1;
      `RSIO_OFS_OUTPUTS:   addrOk = 1'b1;
      default:             addrOk = isMnpAddr(paddr);
    endcase
  end

  // Read data selection
  always @*
  begin
    prdata_next = 32'h0000_0000;
    if (isMnpAddr(paddr))
      prdata_next[`RSIO_MS_W-1:0] = mnpStat[paddr[5:2]];
    else
      case (paddr)
        `RSIO_OFS_CTRL_STAT:
          prdata_next[`RSIO_CS_W-1:0] = ctrlStat_reg;
        `RSIO_OFS_GROUP:
          prdata_next[`RSIO_NUM_W-1:0] = group_reg;
        `RSIO_OFS_EVENTS:
          prdata_next[`RSIO_EV_W-1:0] = events_reg;
        `RSIO_OFS_REMOTE:
          prdata_next[23:0] = {grpLevel, mnpLevel, cmdLevel, sel_reg};
        `RSIO_OFS_OUTPUTS:
          prdata_next = outVector;
        default:
          prdata_next = 32'h0000_0000;
      endcase
  end

  // Phase sequencing: setup, one wait, answer
  always @*
  begin
    case (apbState_reg)
      ST_IDLE:
        apbState_next = (psel && !penable) ? ST_WAIT : ST_IDLE;
      ST_WAIT:
        apbState_next = (psel && penable) ? ST_DONE : ST_WAIT;
      ST_DONE:
        apbState_next = ST_IDLE;
      default:
        apbState_next = ST_IDLE;
    endcase
  end

  // Registered answer signals
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      apbState_reg <= ST_IDLE;
      pready_reg   <= 1'b0;
      pslverr_reg  <= 1'b0;
      prdata_reg   <= 32'h0000_0000;
    end
    else
    begin
      apbState_reg <= apbState_next;
      pready_reg   <= (apbState_next == ST_DONE);
      pslverr_reg  <= (apbState_next == ST_DONE) && !addrOk;
      if (apbState_next == ST_DONE && !pwrite)
        prdata_reg <= prdata_next;
      else
        prdata_reg <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  // Controller state, group and manipulator table
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      ctrlStat_reg <= `RSIO_CS_RESET_VAL;
      group_reg    <= {`RSIO_NUM_W{1'b0}};
      for (k = 0; k < NUM_MNP; k = k + 1)
        mnpStat[k] <= `RSIO_MS_RESET_VAL;
    end
    else if (wrStrobe)
    begin
      if (paddr == `RSIO_OFS_CTRL_STAT)
        ctrlStat_reg <= pwdata[`RSIO_CS_W-1:0];
      if (paddr == `RSIO_OFS_GROUP)
        group_reg <= pwdata[`RSIO_NUM_W-1:0];
      if (isMnpAddr(paddr))
        mnpStat[paddr[5:2]] <= pwdata[`RSIO_MS_W-1:0];
    end
  end

  // Command events: sticky, write one to clear, new event wins
  always @*
  begin
    events_next = events_reg;
    if (wrStrobe && paddr == `RSIO_OFS_EVENTS)
      events_next = events_next & ~pwdata[`RSIO_EV_W-1:0];
    events_next[`RSIO_CMD_W-1:0] =
      events_next[`RSIO_CMD_W-1:0] | cmdPulse;
    if (multiHot(cmdLevel) && (|cmdPulse))
      events_next[`RSIO_EV_COLLISION] = 1'b1;
  end

  // Event register update
  always @(posedge clk_sys)
  begin
    if (rst)
      events_reg <= {`RSIO_EV_W{1'b0}};
    else
      events_reg <= events_next;
  end

  // ----------------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------------
  // Status of the manipulator now selected
  always @*
  begin
    selStat = mnpStat[sel_reg];
  end

  // Every output registered so pins never glitch
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      motorMode_reg   <= 1'b0;
      motorStatus_reg <= 1'b0;
      powerMode_reg   <= 1'b0;
      powerStatus_reg <= 1'b0;
      calibrated_reg  <= 1'b0;
      home_reg        <= 1'b0;
      mnpNum_reg      <= {`RSIO_NUM_W{1'b0}};
      running_reg     <= 1'b0;
      paused_reg      <= 1'b0;
      resetSt_reg     <= 1'b0;
      door_reg        <= 1'b0;
      enable_reg      <= 1'b0;
      estop_reg       <= 1'b0;
      error_reg       <= 1'b0;
      grpNum_reg      <= {`RSIO_NUM_W{1'b0}};
      auto_reg        <= 1'b0;
      supervised_reg  <= 1'b0;
      ready_reg       <= 1'b0;
    end
    else
    begin
      motorMode_reg   <= selStat[`RSIO_MS_MOTOR_MODE];
      motorStatus_reg <= selStat[`RSIO_MS_MOTOR_STAT];
      powerMode_reg   <= selStat[`RSIO_MS_POWER_MODE];
      powerStatus_reg <= selStat[`RSIO_MS_POWER_STAT];
      calibrated_reg  <= selStat[`RSIO_MS_CALIBRATED];
      home_reg        <= selStat[`RSIO_MS_HOME];
      mnpNum_reg      <= sel_reg;
      running_reg     <= ctrlStat_reg[`RSIO_CS_RUN];
      paused_reg      <= ctrlStat_reg[`RSIO_CS_PAUSE];
      resetSt_reg     <= ctrlStat_reg[`RSIO_CS_RESET];
      door_reg        <= ctrlStat_reg[`RSIO_CS_DOOR];
      enable_reg      <= ctrlStat_reg[`RSIO_CS_ENABLE];
      estop_reg       <= ctrlStat_reg[`RSIO_CS_ESTOP];
      error_reg       <= ctrlStat_reg[`RSIO_CS_ERROR];
      grpNum_reg      <= group_reg;
      auto_reg        <= ctrlStat_reg[`RSIO_CS_AUTO];
      supervised_reg  <= ctrlStat_reg[`RSIO_CS_SUPERVISED];
      ready_reg       <= ctrlStat_reg[`RSIO_CS_READY]
                         | ctrlStat_reg[`RSIO_CS_RESET];
    end
  end

  // Readback image of the output pins
  assign outVector = {8'h00, grpNum_reg, mnpNum_reg,
                      ready_reg, supervised_reg, auto_reg, error_reg,
                      estop_reg, enable_reg, door_reg, resetSt_reg,
                      paused_reg, running_reg, home_reg, calibrated_reg,
                      powerStatus_reg, powerMode_reg, motorStatus_reg,
                      motorMode_reg};

  // ----------------------------------------------------------------------
  // Port drive
  // ----------------------------------------------------------------------
  assign prdata              = prdata_reg;
  assign pready              = pready_reg;
  assign pslverr             = pslverr_reg;
  assign motorModeOut        = motorMode_reg;
  assign motorStatusOut      = motorStatus_reg;
  assign powerModeOut        = powerMode_reg;
  assign powerStatusOut      = powerStatus_reg;
  assign originCalibratedOut = calibrated_reg;
  assign homeOut             = home_reg;
  assign mnpNumOut           = mnpNum_reg;
  assign runningOut          = running_reg;
  assign pausedOut           = paused_reg;
  assign resetOut            = resetSt_reg;
  assign safetyDoorOut       = door_reg;
  assign enableSwitchOut     = enable_reg;
  assign estopOut            = estop_reg;
  assign errorOut            = error_reg;
  assign grpNumOut           = grpNum_reg;
  assign autoModeOut         = auto_reg;
  assign supervisedModeOut   = supervised_reg;
  assign readyOut            = ready_reg;

endmodule

/* verif/remote_status_io_monitor.sv */
// Purpose: Port checker for the remote status block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ps
module remote_status_io_monitor
#(parameter TICK_CYCLES = 8, parameter PULSE_TICKS = 10)
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [11:0] remoteCmd,
  input wire logic [3:0]  mnpNumOut,
  input wire logic [3:0]  grpNumOut,
  input wire logic        runningOut,
  input wire logic        resetOut,
  input wire logic        readyOut
);
  localparam int QUAL = (PULSE_TICKS - 1) * TICK_CYCLES;
  logic [15:0] selRun;
  // Cycles the select pin has been high
  always_ff @(posedge clk_sys)
    selRun <= (rst || !remoteCmd[4]) ? 16'h0000 : selRun + 16'h0001;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_rdy_pulse: assert property (pready |=> !pready)
    else $error("pready stood two cycles");
  a_rdy_wait: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("no answer after one wait state");
  a_bad_addr: assert property (pready && paddr == 12'hFFC |-> pslverr)
    else $error("unmapped access not flagged");
  a_prd_idle: assert property (!pready |-> prdata == 32'h00000000)
    else $error("read data outside answer");
  a_ready_or: assert property (resetOut |-> readyOut)
    else $error("ready low in reset state");
  a_run_src: assert property ($changed(runningOut) |-> $past(pready, 2))
    else $error("running output moved without write");
  a_grp_src: assert property ($changed(grpNumOut) |-> $past(pwrite, 2))
    else $error("group output moved without write");
  a_sel_long: assert property ($changed(mnpNumOut) |-> selRun >= QUAL)
    else $error("selection took a short pulse");
  c_err: cover property (pready && pslverr);
  c_sel: cover property ($changed(mnpNumOut));
  c_rdy: cover property (readyOut && !resetOut);
endmodule
bind remote_status_io remote_status_io_monitor
  #(.TICK_CYCLES(TICK_CYCLES), .PULSE_TICKS(PULSE_TICKS)) mon (.clk_sys,
  .rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .remoteCmd, .mnpNumOut, .grpNumOut, .runningOut, .resetOut, .readyOut);

/* verif/remote_panel_model.sv */
// Purpose: Sequencer model driving the remote command pins
// Assumes: Only the manipulator select command is sent
// Notes:   Number bits settle one hold time before the command
`timescale 1ns/1ps
module remote_panel_model
(
  input  wire logic        clk_sys,
  input  wire logic        go,
  input  wire logic [15:0] holdCyc,
  input  wire logic [3:0]  mnpSel,
  output logic             busy,
  output logic [11:0]      remoteCmd,
  output logic [3:0]       remoteMnpNum,
  output logic [3:0]       remoteGrpNum
);
  logic [16:0] cnt;
  initial {busy, remoteCmd, remoteMnpNum, remoteGrpNum} = 21'h000000;
  // One command at a time; on release command lines cleared, number lines inverted
  always @(posedge clk_sys)
  begin
    if (go)
    begin
      busy <= 1'h1;
      cnt <= 17'h00000;
      remoteMnpNum <= mnpSel;
      remoteGrpNum <= mnpSel;
    end
    else if (busy)
    begin
      cnt <= cnt + 17'h00001;
      if (cnt == {1'h0, holdCyc})
        remoteCmd[4] <= 1'h1;
      if (cnt == {holdCyc, 1'h0})
      begin
        remoteCmd <= 12'h000;
        remoteMnpNum <= ~remoteMnpNum;
        remoteGrpNum <= ~remoteGrpNum;
        busy <= 1'h0;
      end
    end
  end
endmodule

/* verif/test_remote_status_io.sv */
// Purpose: Self-checking bench of the remote status block
// Assumes: Fast millisecond tick of 8 clocks
// Notes:   Select pulses come from the panel model
`timescale 1ns/1ps
module test_remote_status_io;
  logic clk_sys = 1'h0, rst = 1'h1, go = 1'h0, busy, er, pready, pslverr;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000, remoteCmd;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] holdCyc = 16'h0000;
  logic [3:0] mnpSel = 4'h0, remoteMnpNum, remoteGrpNum, mnpNumOut, grpNumOut;
  logic motorModeOut, motorStatusOut, powerModeOut, powerStatusOut, homeOut;
  logic originCalibratedOut, runningOut, pausedOut, resetOut, safetyDoorOut;
  logic enableSwitchOut, estopOut, errorOut, autoModeOut, supervisedModeOut;
  logic readyOut;
  int errorCnt = 0, nTests = 0;
  wire [9:0] ctrlOut = {readyOut, supervisedModeOut, autoModeOut, errorOut,
    estopOut, enableSwitchOut, safetyDoorOut, resetOut, pausedOut, runningOut};
  wire [5:0] mnpOut = {homeOut, originCalibratedOut, powerStatusOut,
    powerModeOut, motorStatusOut, motorModeOut};
  remote_status_io #(.TICK_CYCLES(8)) dut (.clk_sys, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .remoteCmd,
    .remoteMnpNum, .remoteGrpNum, .motorModeOut, .motorStatusOut,
    .powerModeOut, .powerStatusOut, .originCalibratedOut, .homeOut,
    .mnpNumOut, .runningOut, .pausedOut, .resetOut, .safetyDoorOut,
    .enableSwitchOut, .estopOut, .errorOut, .grpNumOut, .autoModeOut,
    .supervisedModeOut, .readyOut);
  remote_panel_model pm (.clk_sys, .go, .holdCyc, .mnpSel, .busy,
    .remoteCmd, .remoteMnpNum, .remoteGrpNum);
  always #2 clk_sys = ~clk_sys;
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    nTests++;
    if (g !== e)
    begin
      errorCnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hang(input int k, input int lim);
    if (k >= lim)
    begin
      errorCnt++;
      finish_test();
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int k;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    for (k = 0; k < 16 && pready !== 1'h1; k++) @(posedge clk_sys);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    hang(k, 16);
    @(posedge clk_sys);
  endtask
  // Select pulse from the panel, held h cycles
  task automatic sel(input logic [3:0] n, input logic [15:0] h);
    int k;
    mnpSel <= n;
    holdCyc <= h;
    go <= 1'h1;
    @(posedge clk_sys);
    go <= 1'h0;
    @(posedge clk_sys);
    for (k = 0; k < 1000 && busy !== 1'h0; k++) @(posedge clk_sys);
    hang(k, 1000);
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic t_ctrl;
    logic [9:0] e;
    apb(1'h0, 12'hFFC, 32'h0);
    chk("unmapped", 32'h1, 32'(er));
    chk("rdata", 32'h0, rd);
    for (int i = 0; i < 11; i++)
    begin
      e = 10'h001 << i;
      apb(1'h1, 12'h000, 32'(e));
      @(posedge clk_sys);
      chk("state", 32'(e[3:0]), 32'(ctrlOut[3:0]));
      chk("modes", 32'(e[8:4]), 32'(ctrlOut[8:4]));
      chk("enable", 32'(e[4]), 32'(enableSwitchOut));
      chk("ready", 32'(e[9] | e[2]), 32'(ctrlOut[9]));
    end
    for (int g = 0; g < 16; g += 5)
    begin
      apb(1'h1, 12'h004, 32'(g));
      @(posedge clk_sys);
      chk("group", 32'(g), 32'(grpNumOut));
    end
    $display("controller and group test done");
  endtask
  task automatic t_mnp;
    apb(1'h1, 12'h040, 32'h00000015);
    apb(1'h1, 12'h04C, 32'h0000002A);
    @(posedge clk_sys);
    chk("mnp0", 32'h15, 32'(mnpOut));
    sel(4'h3, 16'h0078);
    chk("number", 32'h3, 32'(mnpNumOut));
    chk("mnp3", 32'h2A, 32'(mnpOut));
    apb(1'h1, 12'h04C, 32'h0000003F);
    @(posedge clk_sys);
    chk("live", 32'h3F, 32'(mnpOut));
    apb(1'h0, 12'h04C, 32'h0);
    chk("readback", 32'h3F, rd);
    sel(4'h0, 16'h0014);
    chk("short", 32'h3, 32'(mnpNumOut));
    $display("manipulator test done");
  endtask
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'h0;
    @(posedge clk_sys);
    t_ctrl();
    t_mnp();
    finish_test();
  end
endmodule
